/* File: ssoe_pkg.sv */
package ssoe_pkg;

  // width of the data pins, parity lanes included
  localparam int SSOE_DATA_W = 36;

  // one-hot select states
  localparam logic [2:0] SSOE_CODE_DESEL = 3'h1;
  localparam logic [2:0] SSOE_CODE_EMERGE = 3'h2;
  localparam logic [2:0] SSOE_CODE_ACTIVE = 3'h4;

  typedef enum logic [2:0] {
    SSOE_DESEL = SSOE_CODE_DESEL,
    SSOE_EMERGE = SSOE_CODE_EMERGE,
    SSOE_ACTIVE = SSOE_CODE_ACTIVE
  } ssoe_sel_e;

  // chip select group as it arrives from the controller
  typedef struct packed {
    logic first_n;
    logic second_hi;
    logic third_n;
  } ssoe_csel_s;

  // whole state of the select and output control block
  typedef struct packed {
    ssoe_sel_e fsm;
    logic sel;
    logic wr_issue;
    logic wr_phase;
    logic permit;
    logic [SSOE_DATA_W-1:0] rd_data;
    logic [SSOE_DATA_W-1:0] wr_data;
    logic wr_valid;
  } ssoe_state_s;

  localparam ssoe_state_s SSOE_STATE_RESET = '{
    fsm: SSOE_DESEL,
    sel: 1'b0,
    wr_issue: 1'b0,
    wr_phase: 1'b0,
    permit: 1'b0,
    rd_data: '0,
    wr_data: '0,
    wr_valid: 1'b0
  };

endpackage

/* File: ssoe_top.sv */
module ssoe_top
  import ssoe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second_hi,
  input wire logic chip_select_third_n,
  input wire logic clock_qualify_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic [SSOE_DATA_W-1:0] read_data,
  input wire logic [SSOE_DATA_W-1:0] data_in,
  output logic [SSOE_DATA_W-1:0] data_out,
  output logic data_oe,
  output logic selected,
  output logic write_phase,
  output logic [SSOE_DATA_W-1:0] write_data,
  output logic write_data_valid
);

  ssoe_state_s state_reg;
  ssoe_state_s state_next;
  ssoe_csel_s csel;
  logic all_active;
  logic edge_ok;

  // group the chip selects and test their active levels
  assign csel.first_n = chip_select_first_n;
  assign csel.second_hi = chip_select_second_hi;
  assign csel.third_n = chip_select_third_n;
  assign all_active = ~csel.first_n & csel.second_hi & ~csel.third_n;
  assign edge_ok = ~clock_qualify_n;

  // next state: on an edge the clock qualifier masks only the write data valid flag clears
  always_comb begin
    state_next = state_reg;
    state_next.wr_valid = 1'b0;
    if (edge_ok) begin
      state_next.sel = all_active;
      // select sequencing through the emerging cycle
      case (state_reg.fsm)
        SSOE_DESEL: begin
          if (all_active) begin
            state_next.fsm = SSOE_EMERGE;
          end else begin
            state_next.fsm = SSOE_DESEL;
          end
        end
        SSOE_EMERGE: begin
          if (all_active) begin
            state_next.fsm = SSOE_ACTIVE;
          end else begin
            state_next.fsm = SSOE_DESEL;
          end
        end
        SSOE_ACTIVE: begin
          if (all_active) begin
            state_next.fsm = SSOE_ACTIVE;
          end else begin
            state_next.fsm = SSOE_DESEL;
          end
        end
        default: begin
          state_next.fsm = SSOE_DESEL;
        end
      endcase
      // write issue then data phase one qualified edge later
      state_next.wr_issue = all_active & ~write_enable_n;
      state_next.wr_phase = state_reg.wr_issue;
      // drivers may only turn on once settled and outside a write data phase
      state_next.permit = all_active
                          & (state_reg.fsm != SSOE_DESEL)
                          & ~state_reg.wr_issue;
      // read data is registered toward the pins
      state_next.rd_data = read_data;
      // write data is taken from the pins during the data phase
      if (state_reg.wr_issue) begin
        state_next.wr_data = data_in;
        state_next.wr_valid = 1'b1;
      end
    end
  end

  // single register bank, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= SSOE_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // output enable gates the driver without waiting for a clock
  assign data_oe = state_reg.permit & ~output_enable_n;

  // outputs taken from the state register
  assign data_out = state_reg.rd_data;
  assign selected = state_reg.sel;
  assign write_phase = state_reg.wr_phase;
  assign write_data = state_reg.wr_data;
  assign write_data_valid = state_reg.wr_valid;

  // checks on select sampling and driver control
  property p_first_low;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && chip_select_first_n) |=> !selected;
  endproperty
  a_first_low: assert property (p_first_low)
    else $error("first select high did not deselect");

  property p_second_high;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && !chip_select_second_hi) |=> !selected;
  endproperty
  a_second_high: assert property (p_second_high)
    else $error("second select low did not deselect");

  property p_third_low;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && chip_select_third_n) |=> !selected;
  endproperty
  a_third_low: assert property (p_third_low)
    else $error("third select high did not deselect");

  property p_all_select;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && all_active) |=> (selected && state_reg.fsm != SSOE_DESEL);
  endproperty
  a_all_select: assert property (p_all_select)
    else $error("all selects active but device not selected");

  property p_oe_async;
    @(posedge ref_clk) disable iff (!reset_n)
      data_oe == (selected && state_reg.fsm == SSOE_ACTIVE && !write_phase && !output_enable_n);
  endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("driver enable not tied to output enable and permit");

  property p_read_drive;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && all_active && state_reg.fsm == SSOE_ACTIVE && !state_reg.wr_issue)
      ##1 !output_enable_n |-> data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("settled read cycle did not drive");

  property p_oe_high;
    @(posedge ref_clk) disable iff (!reset_n)
      output_enable_n |-> !data_oe;
  endproperty
  a_oe_high: assert property (p_oe_high)
    else $error("driving while output enable high");

  property p_write_float;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && state_reg.wr_issue) |=> (write_phase && !data_oe);
  endproperty
  a_write_float: assert property (p_write_float)
    else $error("driving during write data phase");

  property p_emerge_float;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && state_reg.fsm == SSOE_DESEL && all_active) |=> (!data_oe && state_reg.fsm == SSOE_EMERGE);
  endproperty
  a_emerge_float: assert property (p_emerge_float)
    else $error("driving in first cycle after deselection");

  property p_desel_float;
    @(posedge ref_clk) disable iff (!reset_n)
      (!selected || state_reg.fsm == SSOE_DESEL) |-> !data_oe;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("driving while deselected");

  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      clock_qualify_n |=> ($stable(state_reg.fsm) && $stable(selected) && $stable(write_phase));
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved on a masked edge");

  // select state consistency, read against the pins rather than the permit bit
  property p_sel_agree;
    @(posedge ref_clk) disable iff (!reset_n)
      selected == (state_reg.fsm != SSOE_DESEL);
  endproperty
  a_sel_agree: assert property (p_sel_agree)
    else $error("select flag and select state disagree");

  property p_sel_onehot;
    @(posedge ref_clk) disable iff (!reset_n)
      $onehot(state_reg.fsm);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot)
    else $error("select state is not one-hot");

  property p_desel_pins;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && !all_active) |=> (!selected && !data_oe && !state_reg.wr_issue);
  endproperty
  a_desel_pins: assert property (p_desel_pins)
    else $error("inactive select sample left the device on the bus");

  // emerging from deselection: one floating cycle, then the drivers may turn on
  property p_emerge_pins;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && !selected && all_active) |=> !data_oe;
  endproperty
  a_emerge_pins: assert property (p_emerge_pins)
    else $error("drove on the first cycle out of deselection");

  property p_emerge_next;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok && state_reg.fsm == SSOE_EMERGE && all_active) |=> (state_reg.fsm == SSOE_ACTIVE);
  endproperty
  a_emerge_next: assert property (p_emerge_next)
    else $error("emerging cycle did not settle to active");

  property p_emerge_drive;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok && state_reg.fsm == SSOE_EMERGE && all_active && !state_reg.wr_issue)
      ##1 !output_enable_n |-> data_oe;
  endproperty
  a_emerge_drive: assert property (p_emerge_drive)
    else $error("second selected cycle did not drive");

  property p_read_data;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok) |=> (data_out == $past(read_data));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not presented after a qualified edge");

  // write sequence traced from the pins into the data phase
  property p_issue_pins;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok && all_active && !write_enable_n) |=> state_reg.wr_issue;
  endproperty
  a_issue_pins: assert property (p_issue_pins)
    else $error("selected write was not issued");

  property p_write_pins;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok && all_active && !write_enable_n) ##1 edge_ok |=> (write_phase && !data_oe);
  endproperty
  a_write_pins: assert property (p_write_pins)
    else $error("write data phase did not float the drivers");

  property p_capture;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok && state_reg.wr_issue) |=> (write_data_valid && write_data == $past(data_in));
  endproperty
  a_capture: assert property (p_capture)
    else $error("write data not taken from the pins in the data phase");

  property p_valid_issue;
    @(posedge ref_clk) disable iff (!reset_n)
      (edge_ok && !state_reg.wr_issue) |=> !write_data_valid;
  endproperty
  a_valid_issue: assert property (p_valid_issue)
    else $error("write data valid without an issued write");

  property p_phase_end;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && edge_ok && state_reg.wr_issue && !(all_active && !write_enable_n))
      ##1 edge_ok |=> !write_phase;
  endproperty
  a_phase_end: assert property (p_phase_end)
    else $error("write data phase outlived its write");

  // masked edges keep every registered output except write data valid, which clears
  property p_masked_valid;
    @(posedge ref_clk) disable iff (!reset_n)
      clock_qualify_n |=> !write_data_valid;
  endproperty
  a_masked_valid: assert property (p_masked_valid)
    else $error("write data valid raised on a masked edge");

  property p_masked_data;
    @(posedge ref_clk) disable iff (!reset_n)
      (reset_n && clock_qualify_n) |=> ($stable(data_out) && $stable(write_data) && $stable(state_reg.permit));
  endproperty
  a_masked_data: assert property (p_masked_data)
    else $error("data or driver permission moved on a masked edge");

  // reset leaves the device deselected and off the bus
  property p_reset_idle;
    @(posedge ref_clk)
      !reset_n |=> (!selected && !write_phase && !write_data_valid && !data_oe);
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("device not idle after reset");

endmodule

/* File: ssoe_ctrl_model.sv */
module ssoe_ctrl_model
  import ssoe_pkg::*;
(
  input wire logic ref_clk,
  output ssoe_csel_s csel,
  output logic qualify_n,
  output logic wr_n,
  output logic oe_n,
  output logic [SSOE_DATA_W-1:0] bus_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // controller idles deselected with drivers off
  initial begin
    csel = 3'h5;
    qualify_n = 1'b0;
    wr_n = 1'b1;
    oe_n = 1'b1;
    bus_data = '0;
  end
  // one controller cycle, launched just after the edge and held until the next
  task automatic drive(input logic [2:0] cs, input logic we, input logic oe, input logic q, input logic wr,
                       input logic [SSOE_DATA_W-1:0] d);
    @(posedge ref_clk);
    csel <= cs;
    wr_n <= we;
    oe_n <= oe;
    qualify_n <= q;
    bus_data <= wr ? d : ~bus_data; // released bus never keeps its last value
  endtask
endmodule

/* File: sram_select_output_enable_bench.sv */
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module sram_select_output_enable_bench
  import ssoe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [SSOE_DATA_W-1:0] rd = '0;
  ssoe_csel_s csel;
  logic qual_n, we_n, oe_n, doe, sel, wph, wval;
  logic [SSOE_DATA_W-1:0] bus_d, dout, wdat;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [SSOE_DATA_W-1:0] RD_V = 36'h9a5c33c5a;
  localparam logic [SSOE_DATA_W-1:0] WR_V = 36'h50f0ff0f1;
  // clock and hang guard
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 600) begin
      n_errors++;
      results();
    end
  end
  ssoe_ctrl_model i_ctrl (.ref_clk(ref_clk), .csel(csel), .qualify_n(qual_n), .wr_n(we_n), .oe_n(oe_n),
    .bus_data(bus_d));
  ssoe_top i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .chip_select_first_n(csel.first_n),
    .chip_select_second_hi(csel.second_hi), .chip_select_third_n(csel.third_n), .clock_qualify_n(qual_n),
    .write_enable_n(we_n), .output_enable_n(oe_n), .read_data(rd), .data_in(bus_d), .data_out(dout),
    .data_oe(doe), .selected(sel), .write_phase(wph), .write_data(wdat), .write_data_valid(wval));
  // each single inactive select keeps the device off the bus
  task automatic t_select();
    logic [2:0] pat [3] = '{3'h6, 3'h0, 3'h3};
    foreach (pat[i]) begin
      i_ctrl.drive(pat[i], 1'b1, 1'b0, 1'b0, 1'b0, '0);
      i_ctrl.drive(pat[i], 1'b1, 1'b0, 1'b0, 1'b0, '0);
      #1;
      `CHK(sel, 1'b0)
      `CHK(doe, 1'b0)
    end
    $display("select test done");
  endtask
  // read from deselection: emerge cycle floats, then drive, then output enable cuts off
  task automatic t_read();
    i_ctrl.drive(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    i_ctrl.drive(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    rd <= RD_V;
    #1;
    `CHK(sel, 1'b1)
    `CHK(doe, 1'b0)
    i_ctrl.drive(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    #1;
    `CHK(doe, 1'b1)
    `CHK(dout, RD_V)
    i_ctrl.drive(3'h2, 1'b1, 1'b1, 1'b0, 1'b0, '0);
    #1;
    `CHK(sel, 1'b1)
    `CHK(doe, 1'b0)
    $display("read test done");
  endtask
  // write while active with output enable low: data phase stays off the bus
  task automatic t_write();
    i_ctrl.drive(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, '0);
    i_ctrl.drive(3'h2, 1'b1, 1'b0, 1'b0, 1'b1, WR_V);
    i_ctrl.drive(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    #1;
    `CHK(wph, 1'b1)
    `CHK(wval, 1'b1)
    `CHK(wdat, WR_V)
    `CHK(doe, 1'b0)
    $display("write test done");
  endtask
  // masked edges hold selection, the next enabled edge deselects
  task automatic t_qualify();
    i_ctrl.drive(3'h5, 1'b1, 1'b0, 1'b1, 1'b0, '0);
    i_ctrl.drive(3'h5, 1'b1, 1'b0, 1'b1, 1'b0, '0);
    i_ctrl.drive(3'h5, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    #1;
    `CHK(sel, 1'b1)
    `CHK(doe, 1'b1)
    i_ctrl.drive(3'h5, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    #1;
    `CHK(sel, 1'b0)
    `CHK(doe, 1'b0)
    $display("qualify test done");
  endtask
  // counts and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_select();
    t_read();
    t_write();
    t_qualify();
    results();
  end
endmodule
